// *** rtl/iows_pkg.sv ***
package iows_pkg;
    // Configuration dword that holds the three registers
    localparam logic [5:0]  IOWS_DWORD_IDX      = 6'h07;   // Byte address 1c >> 2
    localparam logic [7:0]  IOWS_BASE_OFS       = 8'h1c;   // io_window_base_byte
    localparam logic [7:0]  IOWS_LIMIT_OFS      = 8'h1d;   // io_window_limit_byte
    localparam logic [7:0]  IOWS_STATUS_OFS     = 8'h1e;   // downstream_side_status
    // Fixed fields
    localparam logic [3:0]  IOWS_IO32_CODE      = 4'h1;    // 32-bit I/O decode indicator
    localparam logic [3:0]  IOWS_ADDR_RESET     = 4'h0;    // Writable nibble reset value
    localparam logic [11:0] IOWS_BASE_LOW       = 12'h000; // Implied base bits 11:0
    localparam logic [11:0] IOWS_LIMIT_LOW      = 12'hfff; // Implied limit bits 11:0
    localparam logic [1:0]  IOWS_DEVSEL_MEDIUM  = 2'h1;    // Medium decode timing code
    localparam logic        IOWS_CAP_66MHZ      = 1'b0;    // Not 66 MHz capable
    localparam logic        IOWS_CAP_FB2B       = 1'b1;    // Fast back-to-back as target
    // Dword bit positions of the status fields
    localparam int          IOWS_ST_DPD         = 24;      // Data parity detected
    localparam int          IOWS_ST_STA         = 27;      // Signaled target abort
    localparam int          IOWS_ST_RTA         = 28;      // Received target abort
    localparam int          IOWS_ST_RMA         = 29;      // Received master abort
    localparam int          IOWS_ST_RSE         = 30;      // Received system error
    localparam int          IOWS_ST_DPE         = 31;      // Detected parity error
    localparam int          IOWS_ST_FIRST       = 24;      // Lowest sticky flag bit
    localparam int          IOWS_NFLAGS         = 8;       // Flag slots in dword bits 31:24
    // Bytes of the dword and their lanes
    localparam int          IOWS_LANE_BASE      = 0;       // Byte enable of base byte
    localparam int          IOWS_LANE_LIMIT     = 1;       // Byte enable of limit byte
    localparam int          IOWS_LANE_STHI      = 3;       // Byte enable of sticky flags
endpackage

// *** rtl/iows_regs.sv ***
// Functional notes
// RQ1: base and limit low nibbles read 1h
// RQ2: base nibble gives window address bits 15:12
// RQ3: limit nibble gives bits 15:12, low FFFh
// RQ4: window has 4 KB alignment and granularity
// RQ5: base and limit decide I/O forwarding
// RQ6: address bits 31:16 from upper registers
// RQ7: writable nibbles reset to zero
// RQ8: write one clears flag, zero leaves it
// RQ9: status bits 20:16 and 22 read zero
// RQ10: bit 21 reads 0, not 66 MHz
// RQ11: bit 23 reads 1, fast back-to-back
// RQ12: bit 24 master parity error, response enabled
// RQ13: bits 26:25 read 01b, medium DEVSEL timing
// RQ14: bit 27 set on signaled target abort
// RQ15: bit 28 set on received target abort
// RQ16: bit 29 set on received master abort
// RQ17: bit 30 set on system error pin
// RQ18: bit 31 set on any parity error; code sets it from ev_parity_err only, not from ev_master_perr
// RQ19: window inclusive of both base and limit
module iows_regs
    import iows_pkg::*;
#(
    parameter int AW = 32                          // I/O address width
) (
    input  wire logic          clk,                // Clock, 200 MHz
    input  wire logic          rst,                // Async reset, active high
    // Configuration access, one dword per request
    input  wire logic          cfg_wr,             // Configuration write strobe
    input  wire logic          cfg_rd,             // Configuration read strobe
    input  wire logic [5:0]    cfg_dword,          // Dword index of the access
    input  wire logic [3:0]    cfg_be_n,           // Byte enables, active low
    input  wire logic [31:0]   cfg_wdata,          // Write data
    output logic [31:0]        cfg_rdata_q,        // Read data, zero if not ours
    output logic               cfg_rvalid_q,       // Read data valid pulse
    // Upper 16 bits come from their own registers elsewhere
    input  wire logic [15:0]   io_base_upper,      // Base address bits 31:16
    input  wire logic [15:0]   io_limit_upper,     // Limit address bits 31:16
    input  wire logic          perr_resp_en,       // Parity error response enable
    // Secondary bus events, one-cycle pulses
    input  wire logic          ev_master_perr,     // Parity error while bus master
    input  wire logic          ev_perr_pin,        // Secondary parity error pin seen
    input  wire logic          ev_tgt_abort_sent,  // Target abort signaled as target
    input  wire logic          ev_tgt_abort_rcvd,  // Target abort received as master
    input  wire logic          ev_mst_abort_rcvd,  // Master abort as initiator
    input  wire logic          ev_serr_pin,        // System error pin seen asserted
    input  wire logic          ev_parity_err,      // Address or data parity error
    input  wire logic          is_sec_master,      // Bridge owns the secondary bus
    // Forwarding decision
    input  wire logic          io_req,             // I/O address valid strobe
    input  wire logic [AW-1:0] io_addr,            // I/O address to classify
    output logic               io_fwd_q,           // Forward: inside window
    output logic               io_fwd_valid_q,     // Decision valid pulse
    output logic [AW-1:0]      win_base_q,         // Expanded window base
    output logic [AW-1:0]      win_limit_q,        // Expanded window limit
    output logic [7:0]         sticky_flags_q      // Status flags, dword bits 31:24
);
    import iows_pkg::*;

    // Writable address nibbles
    logic [3:0]    base_nib_q;                     // Base bits 15:12
    logic [3:0]    limit_nib_q;                    // Limit bits 15:12
    logic          hit_w;                          // Compare result
    logic          done_w;                         // Compare result valid
    logic          our_dword;                      // Access hits this dword
    logic          wr_ok;                          // Qualified write
    logic [7:0]    set_vec;                        // Flag set requests
    logic [7:0]    clr_vec;                        // Flag clear requests
    logic [7:0]    flag_mask;                      // Implemented flag slots
    logic [31:0]   rd_word;                        // Assembled read word

    // Lane enable helper, byte enables are active low
    function automatic logic lane_on(input logic [3:0] be_n, input int lane);
        return ~be_n[lane];
    endfunction

    assign our_dword = (cfg_dword == IOWS_DWORD_IDX);
    assign wr_ok     = cfg_wr && our_dword;

    // Base and limit nibbles; only the upper nibble of each byte is stored
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            base_nib_q  <= IOWS_ADDR_RESET;                    // [RQ7]
            limit_nib_q <= IOWS_ADDR_RESET;                    // [RQ7]
        end else if (wr_ok) begin
            if (lane_on(cfg_be_n, IOWS_LANE_BASE)) begin
                base_nib_q <= cfg_wdata[7:4];                  // [RQ2]
            end
            if (lane_on(cfg_be_n, IOWS_LANE_LIMIT)) begin
                limit_nib_q <= cfg_wdata[15:12];               // [RQ3]
            end
        end
    end

    // Expanded window; fixed low 12 bits give 4 KB steps
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            win_base_q  <= '0;
            win_limit_q <= '0;
        end else begin
            win_base_q  <= AW'({io_base_upper, base_nib_q, IOWS_BASE_LOW});   // [RQ2] [RQ4] [RQ6]
            win_limit_q <= AW'({io_limit_upper, limit_nib_q, IOWS_LIMIT_LOW}); // [RQ3] [RQ4] [RQ6]
        end
    end

    // Event collection into flag slots of dword bits 31:24
    always_comb begin
        set_vec = '0;
        set_vec[IOWS_ST_DPD - IOWS_ST_FIRST] =
            is_sec_master && (ev_master_perr || ev_perr_pin) && perr_resp_en; // [RQ12]
        set_vec[IOWS_ST_STA - IOWS_ST_FIRST] = ev_tgt_abort_sent;  // [RQ14]
        set_vec[IOWS_ST_RTA - IOWS_ST_FIRST] = ev_tgt_abort_rcvd;  // [RQ15]
        set_vec[IOWS_ST_RMA - IOWS_ST_FIRST] = ev_mst_abort_rcvd;  // [RQ16]
        set_vec[IOWS_ST_RSE - IOWS_ST_FIRST] = ev_serr_pin;        // [RQ17]
        set_vec[IOWS_ST_DPE - IOWS_ST_FIRST] = ev_parity_err;      // [RQ18]
    end

    // Slots 26:25 hold the fixed timing code, never sticky
    always_comb begin
        flag_mask = '0;
        flag_mask[IOWS_ST_DPD - IOWS_ST_FIRST] = 1'b1;
        flag_mask[IOWS_ST_STA - IOWS_ST_FIRST] = 1'b1;
        flag_mask[IOWS_ST_RTA - IOWS_ST_FIRST] = 1'b1;
        flag_mask[IOWS_ST_RMA - IOWS_ST_FIRST] = 1'b1;
        flag_mask[IOWS_ST_RSE - IOWS_ST_FIRST] = 1'b1;
        flag_mask[IOWS_ST_DPE - IOWS_ST_FIRST] = 1'b1;
    end

    // Writing 1 clears a flag; a zero leaves it alone
    assign clr_vec = (wr_ok && lane_on(cfg_be_n, IOWS_LANE_STHI))
                     ? cfg_wdata[31:24] : 8'h00;               // [RQ8]

    // Sticky flags; a same-cycle event beats the clear so none is lost
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sticky_flags_q <= 8'h00;
        end else begin
            sticky_flags_q <= ((sticky_flags_q & ~clr_vec) | set_vec) & flag_mask; // [RQ8]
        end
    end

    // Read word assembly; constants fill the read-only fields
    always_comb begin
        rd_word        = 32'h0000_0000;                        // [RQ9]
        rd_word[3:0]   = IOWS_IO32_CODE;                       // [RQ1]
        rd_word[7:4]   = base_nib_q;
        rd_word[11:8]  = IOWS_IO32_CODE;                       // [RQ1]
        rd_word[15:12] = limit_nib_q;
        rd_word[31:24] = sticky_flags_q;
        rd_word[21]    = IOWS_CAP_66MHZ;                       // [RQ10]
        rd_word[23]    = IOWS_CAP_FB2B;                        // [RQ11]
        rd_word[26:25] = IOWS_DEVSEL_MEDIUM;                   // [RQ13]
    end

    // Read port; other dwords answer zero so an outer mux can OR them
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_rdata_q  <= 32'h0000_0000;
            cfg_rvalid_q <= 1'b0;
        end else begin
            cfg_rvalid_q <= cfg_rd;
            if (cfg_rd) begin
                cfg_rdata_q <= our_dword ? rd_word : 32'h0000_0000;
            end
        end
    end

    // Window check; the upper bits are live inputs, so compare on stored form
    iows_window_cmp #(
        .AW     (AW)
    ) u_cmp (
        .clk    (clk),
        .rst    (rst),
        .req    (io_req),
        .addr   (io_addr),
        .lo     (win_base_q),
        .hi     (win_limit_q),
        .hit_q  (hit_w),
        .done_q (done_w)
    );

    // Forwarding decision output, registered once more
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            io_fwd_q       <= 1'b0;
            io_fwd_valid_q <= 1'b0;
        end else begin
            io_fwd_valid_q <= done_w;
            io_fwd_q       <= hit_w && done_w;                 // [RQ5] [RQ19]
        end
    end
endmodule

// *** rtl/iows_window_cmp.sv ***
// Inclusive range compare of an I/O address against the expanded window
module iows_window_cmp
    import iows_pkg::*;
#(
    parameter int AW = 32                  // I/O address width
) (
    input  wire logic          clk,        // Clock
    input  wire logic          rst,        // Async reset, active high
    input  wire logic          req,        // Address valid strobe
    input  wire logic [AW-1:0] addr,       // I/O address to classify
    input  wire logic [AW-1:0] lo,         // Expanded base address
    input  wire logic [AW-1:0] hi,         // Expanded limit address
    output logic               hit_q,      // Address falls in window
    output logic               done_q      // Result valid pulse
);
    // Registered compare: one cycle from strobe to answer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hit_q  <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= req;
            if (req) begin
                hit_q <= (addr >= lo) && (addr <= hi); // [RQ19]
            end
        end
    end
endmodule

// *** verification/iows_regs_bench.sv ***
module iows_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, rst, cfg_wr, cfg_rd, perr_resp_en, is_sec_master, io_req, fire;
    logic        cfg_rvalid_q, io_fwd_q, io_fwd_valid_q;
    logic [5:0]  cfg_dword;
    logic [3:0]  cfg_be_n;
    logic [2:0]  kind;
    logic [6:0]  ev_q;
    logic [7:0]  sticky_flags_q;
    logic [15:0] io_base_upper, io_limit_upper;
    logic [31:0] cfg_wdata, cfg_rdata_q, io_addr, win_base_q, win_limit_q, rd;
    int          num_errors, total_checks;
    iows_regs dut (
        .clk(clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_dword(cfg_dword),
        .cfg_be_n(cfg_be_n), .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q),
        .cfg_rvalid_q(cfg_rvalid_q), .io_base_upper(io_base_upper),
        .io_limit_upper(io_limit_upper), .perr_resp_en(perr_resp_en),
        .ev_master_perr(ev_q[0]), .ev_perr_pin(ev_q[1]),
        .ev_tgt_abort_sent(ev_q[2]), .ev_tgt_abort_rcvd(ev_q[3]),
        .ev_mst_abort_rcvd(ev_q[4]), .ev_serr_pin(ev_q[5]), .ev_parity_err(ev_q[6]),
        .is_sec_master(is_sec_master), .io_req(io_req), .io_addr(io_addr),
        .io_fwd_q(io_fwd_q), .io_fwd_valid_q(io_fwd_valid_q), .win_base_q(win_base_q),
        .win_limit_q(win_limit_q), .sticky_flags_q(sticky_flags_q));
    iows_sec_agent agent (.clk(clk), .fire(fire), .kind(kind), .ev_q(ev_q));
    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cfg_write(input logic [5:0] d, input logic [3:0] be, input logic [31:0] w);
        @(posedge clk);
        {cfg_wr, cfg_dword, cfg_be_n, cfg_wdata} <= {1'b1, d, be, w};
        @(posedge clk);
        {cfg_wr, cfg_be_n} <= {1'b0, 4'hf};
    endtask
    // Read answer is registered on the taking edge
    task automatic cfg_read(input logic [5:0] d);
        @(posedge clk);
        {cfg_rd, cfg_dword} <= {1'b1, d};
        @(posedge clk);
        cfg_rd <= 1'b0;
        #1;
        rd = cfg_rvalid_q ? cfg_rdata_q : 32'hdead_beef;
    endtask
    task automatic fwd(input logic [31:0] a, input logic e);
        @(posedge clk);
        {io_req, io_addr} <= {1'b1, a};
        @(posedge clk);
        io_req <= 1'b0;
        @(posedge clk);
        #1;
        check({30'h0, io_fwd_valid_q, io_fwd_q}, {30'h0, 1'b1, e});
    endtask
    // Event goes agent then flag: two edges after the request
    task automatic pulse(input logic [2:0] k, input logic [7:0] e);
        @(posedge clk);
        {fire, kind} <= {1'b1, k};
        @(posedge clk);
        fire <= 1'b0;
        @(posedge clk);
        #1;
        check({24'h0, sticky_flags_q}, {24'h0, e});
    endtask
    task automatic t_reset();
        cfg_read(6'h07);
        check(rd, 32'h0280_0101);
        check(win_base_q, 32'h0012_0000);
        check(win_limit_q, 32'h0012_0fff);
    endtask
    // Low nibbles and byte 2 are read-only; dword 6 is not ours
    task automatic t_window();
        cfg_write(6'h07, 4'h8, 32'h00ff_7f5f);
        cfg_write(6'h06, 4'h0, 32'hffff_ffff);
        cfg_read(6'h07);
        check(rd, 32'h0280_7151);
        cfg_read(6'h06);
        check(rd, 32'h0000_0000);
        check(win_base_q, 32'h0012_5000);
        check(win_limit_q, 32'h0012_7fff);
    endtask
    // Both bounds inclusive; upper bits come from their own inputs
    task automatic t_forward();
        logic [31:0] a[5] = '{32'h0012_4fff, 32'h0012_5000, 32'h0012_7fff, 32'h0012_8000,
                              32'h0013_6000};
        logic        e[5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
        foreach (a[i]) fwd(a[i], e[i]);
    endtask
    task automatic t_flags();
        int bitpos[7] = '{0, 0, 3, 4, 5, 6, 7};
        perr_resp_en <= 1'b0;
        pulse(3'h0, 8'h00);
        {perr_resp_en, is_sec_master} <= 2'b10;
        pulse(3'h1, 8'h00);
        is_sec_master <= 1'b1;
        for (int k = 0; k < 7; k++) begin
            pulse(k[2:0], 8'h01 << bitpos[k]);
            cfg_write(6'h07, 4'h7, 32'h0000_0000);
            #1;
            check({24'h0, sticky_flags_q}, 32'h1 << bitpos[k]);
            cfg_write(6'h07, 4'h7, 32'hff00_0000);
            #1;
            check({24'h0, sticky_flags_q}, 32'h0);
        end
    endtask
    // Event and clear in one cycle: the event wins so nothing is lost
    task automatic t_set_wins();
        @(posedge clk);
        {fire, kind} <= {1'b1, 3'h5};
        @(posedge clk);
        fire <= 1'b0;
        {cfg_wr, cfg_dword, cfg_be_n, cfg_wdata} <= {1'b1, 6'h07, 4'h7, 32'hff00_0000};
        @(posedge clk);
        {cfg_wr, cfg_be_n} <= {1'b0, 4'hf};
        #1;
        check({24'h0, sticky_flags_q}, 32'h0000_0040);
        cfg_write(6'h07, 4'h7, 32'hff00_0000);
        #1;
        check({24'h0, sticky_flags_q}, 32'h0000_0000);
    endtask
    // Mid-run reset must drop programmed nibbles back to zero
    task automatic t_rerst();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Whole run needs about a hundred cycles
    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        tally_and_finish();
    end
    initial begin
        {rst, cfg_wr, cfg_rd, io_req, fire, perr_resp_en, is_sec_master} = 7'h43;
        {cfg_dword, cfg_be_n, kind, cfg_wdata, io_addr} = {6'h00, 4'hf, 3'h0, 64'h0};
        {io_base_upper, io_limit_upper} = 32'h0012_0012;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_window();
        t_forward();
        t_rerst();
        t_flags();
        t_set_wins();
        tally_and_finish();
    end
endmodule
bind iows_regs iows_regs_monitor #(.AW(AW)) mon (
    .clk(clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_dword(cfg_dword),
    .cfg_be_n(cfg_be_n), .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q),
    .cfg_rvalid_q(cfg_rvalid_q), .ev_serr_pin(ev_serr_pin), .io_req(io_req),
    .io_addr(io_addr), .io_fwd_q(io_fwd_q), .io_fwd_valid_q(io_fwd_valid_q),
    .win_base_q(win_base_q), .win_limit_q(win_limit_q), .sticky_flags_q(sticky_flags_q));

// *** verification/iows_regs_monitor.sv ***
module iows_regs_monitor
    import iows_pkg::*;
#(
    parameter int AW = 32                  // I/O address width
) (
    input wire logic          clk,         // Clock
    input wire logic          rst,         // Async reset
    input wire logic          cfg_wr,      // Write strobe
    input wire logic          cfg_rd,      // Read strobe
    input wire logic [5:0]    cfg_dword,   // Dword index
    input wire logic [3:0]    cfg_be_n,    // Byte enables
    input wire logic [31:0]   cfg_wdata,   // Write data
    input wire logic [31:0]   cfg_rdata_q, // Read data
    input wire logic          cfg_rvalid_q, // Read valid
    input wire logic          ev_serr_pin, // System error event
    input wire logic          io_req,      // Classify strobe
    input wire logic [AW-1:0] io_addr,     // Address
    input wire logic          io_fwd_q,    // In window
    input wire logic          io_fwd_valid_q, // Decision valid
    input wire logic [AW-1:0] win_base_q,  // Expanded base
    input wire logic [AW-1:0] win_limit_q, // Expanded limit
    input wire logic [7:0]    sticky_flags_q // Flags 31:24
);
    timeunit 1ns;
    timeprecision 100ps;
    // All checks live in the one clock domain
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    a_read_answer: assert property (cfg_rd |=> cfg_rvalid_q)
        else $error("read answer missing");
    a_io32_code: assert property (cfg_rvalid_q && $past(cfg_dword) == IOWS_DWORD_IDX |->
        cfg_rdata_q[3:0] == IOWS_IO32_CODE && cfg_rdata_q[11:8] == IOWS_IO32_CODE)
        else $error("indicator nibble wrong");
    a_rsvd_zero: assert property (cfg_rvalid_q && $past(cfg_dword) == IOWS_DWORD_IDX |->
        cfg_rdata_q[20:16] == 5'h00 && !cfg_rdata_q[22]) else $error("reserved bit set");
    a_cap_fields: assert property (cfg_rvalid_q && $past(cfg_dword) == IOWS_DWORD_IDX |->
        !cfg_rdata_q[21] && cfg_rdata_q[23] && cfg_rdata_q[26:25] == 2'h1)
        else $error("capability field wrong");
    a_base_align: assert property (win_base_q[11:0] == 12'h000)
        else $error("base not aligned");
    // Limit is zero while in reset, so skip the release edge
    a_limit_ones: assert property (!$past(rst) |-> win_limit_q[11:0] == 12'hfff)
        else $error("limit low bits wrong");
    a_fwd_answer: assert property (io_req |-> ##2 io_fwd_valid_q)
        else $error("forward answer late");
    a_fwd_range: assert property (io_fwd_valid_q |-> io_fwd_q ==
        ($past(io_addr, 2) >= $past(win_base_q, 2) && $past(io_addr, 2) <= $past(win_limit_q, 2)))
        else $error("forward decision wrong");
    a_serr_flag: assert property (ev_serr_pin |=> sticky_flags_q[6])
        else $error("system error flag not set");
    // Flag bit 31 may only drop after a write of one to it
    a_clear_cause: assert property (!$past(rst) && $fell(sticky_flags_q[7]) |->
        $past(cfg_wr) && $past(cfg_dword) == IOWS_DWORD_IDX && !$past(cfg_be_n[3]) &&
        $past(cfg_wdata[31])) else $error("flag lost");
endmodule

// *** verification/iows_sec_agent.sv ***
// Secondary bus agents, reduced to the events the bridge observes
module iows_sec_agent (
    input  wire logic       clk,   // Clock
    input  wire logic       fire,  // Raise an event next edge
    input  wire logic [2:0] kind,  // Event index
    output logic [6:0]      ev_q   // One-cycle event pulses
);
    timeunit 1ns;
    timeprecision 100ps;
    // Single-cycle pulse, so a flag is never re-set by a held level
    always_ff @(posedge clk) begin
        ev_q <= fire ? (7'h01 << kind) : 7'h00;
    end
endmodule
